/* hdl/adt_trim_bank.sv */
// Analog die test and trim register bank with decoded trim outputs
//
// Contract
// - Production test resets zero, never written.
// - Two-bit field selects over-current filter delay.
// - Reset clears delay select: longest delay.
// - Trim one bits five, four read zero.
// - Low nibble trims internal current references.
// - Reset clears current reference trim to zero.
// - Trim two top bits: bridge pair A low.
// - Trim two bits 5:3: bridge pair B high.
// - Trim two bits 2:0: bridge pair A high.
// - Trim three top bits: bridge pair B low.
// - Trim three bits 5:3: high-side pair.
// - Trim three bits 2:0: high-side one.
// - Reset clears all recopy trim fields.
// - Trim two and three read zero.
`timescale 1ns/100ps
module adt_trim_bank #(
  parameter int OC_CYC0 = adt_pkg::ADT_OC_CYC0,
  parameter int OC_CYC1 = adt_pkg::ADT_OC_CYC1,
  parameter int OC_CYC2 = adt_pkg::ADT_OC_CYC2,
  parameter int OC_CYC3 = adt_pkg::ADT_OC_CYC3,
  parameter int CNT_W = adt_pkg::ADT_OC_CNT_W
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire adt_pkg::adt_req_type i_req,
  input wire logic i_oc_raw,
  input wire logic i_oc_clear,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic [1:0] o_overcurrent_filter_delay_select,
  output logic [3:0] o_current_reference_trim,
  output adt_pkg::adt_trim_type o_recopy_trim,
  output logic signed [7:0] o_reference_adjust_pct,
  output logic signed [adt_pkg::ADT_NUM_RECOPY-1:0][7:0] o_recopy_adjust_pct,
  output logic o_reserved_code,
  output logic [2:0] o_trim_loaded,
  output logic o_oc_shutdown
);
  import adt_pkg::*;

  // Refuse filter counts that the counter cannot hold
  if (OC_CYC0 < 1 || OC_CYC1 < 1 || OC_CYC2 < 1 || OC_CYC3 < 1) begin : g_chk_min
    $error("filter cycle counts must be at least one");
  end
  if (OC_CYC0 >= 2**CNT_W || OC_CYC1 >= 2**CNT_W || OC_CYC2 >= 2**CNT_W ||
      OC_CYC3 >= 2**CNT_W) begin : g_chk_max
    $error("filter cycle count does not fit the counter width");
  end

  // Stored fields
  logic [1:0] dly_sel_q;
  logic [3:0] ref_trim_q;
  adt_trim_type trim_q;
  logic [2:0] loaded_q;
  logic [7:0] rd_data_q;
  logic rd_valid_q;
  logic signed [7:0] ref_pct_q;
  logic signed [ADT_NUM_RECOPY-1:0][7:0] recopy_pct_q;
  logic reserved_q;
  logic oc_meta_q;
  logic oc_sync_q;

  // Next values
  logic [1:0] dly_sel_d;
  logic [3:0] ref_trim_d;
  adt_trim_type trim_d;
  logic [2:0] loaded_d;
  logic [7:0] rd_data_d;

  // Address decode of the register port
  wire logic hit_test = (i_req.addr == ADT_OFS_PROD_TEST);
  wire logic hit_one = (i_req.addr == ADT_OFS_TRIM_ONE);
  wire logic hit_two = (i_req.addr == ADT_OFS_TRIM_TWO);
  wire logic hit_three = (i_req.addr == ADT_OFS_TRIM_THREE);
  wire logic wr_one = i_req.wr && hit_one;
  wire logic wr_two = i_req.wr && hit_two;
  wire logic wr_three = i_req.wr && hit_three;

  // Production test register has no storage, so a write there has nothing to change
  wire logic wr_test_dropped = i_req.wr && hit_test;

  // Trim register one: delay select is read/write, reserved bits dropped
  assign dly_sel_d = wr_one ? i_req.wdata[ADT_DLY_LSB+:2] : dly_sel_q;
  assign ref_trim_d = wr_one ? i_req.wdata[ADT_REF_LSB+:4] : ref_trim_q;

  // Trim register two: bridge pair fields
  assign trim_d.bridge_pair_a_low_sense_trim = wr_two ?
      i_req.wdata[ADT_LOW_LSB+:2] : trim_q.bridge_pair_a_low_sense_trim;
  assign trim_d.bridge_pair_b_high_sense_trim = wr_two ?
      i_req.wdata[ADT_HIGH_B_LSB+:3] : trim_q.bridge_pair_b_high_sense_trim;
  assign trim_d.bridge_pair_a_high_sense_trim = wr_two ?
      i_req.wdata[ADT_HIGH_A_LSB+:3] : trim_q.bridge_pair_a_high_sense_trim;

  // Trim register three: bridge pair B low sense and high-side fields
  assign trim_d.bridge_pair_b_low_sense_trim = wr_three ?
      i_req.wdata[ADT_LOW_LSB+:2] : trim_q.bridge_pair_b_low_sense_trim;
  assign trim_d.high_side_pair_trim = wr_three ?
      i_req.wdata[ADT_HIGH_B_LSB+:3] : trim_q.high_side_pair_trim;
  assign trim_d.high_side_one_trim = wr_three ?
      i_req.wdata[ADT_HIGH_A_LSB+:3] : trim_q.high_side_one_trim;

  // Which trim registers were written since reset; software has no other view of this
  assign loaded_d = loaded_q | {wr_three, wr_two, wr_one};

  // Read data: reserved and write-only bits return zero
  wire logic [7:0] rd_one = {dly_sel_q, 2'b00, 4'h0};
  assign rd_data_d = !i_req.rd ? rd_data_q :
                     hit_test ? ADT_RST_PROD_TEST :
                     hit_one ? rd_one :
                     (hit_two || hit_three) ? ADT_READ_ZERO :
                     ADT_READ_ZERO;

  // Register storage; reset gives the longest delay and no trim adjustment
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      dly_sel_q <= ADT_RST_TRIM[ADT_DLY_LSB+:2];
      ref_trim_q <= ADT_RST_TRIM[ADT_REF_LSB+:4];
      trim_q <= '0;
      loaded_q <= 3'h0;
    end else begin
      dly_sel_q <= dly_sel_d;
      ref_trim_q <= ref_trim_d;
      trim_q <= trim_d;
      loaded_q <= loaded_d;
    end
  end

  // Read answer one cycle after the request
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rd_data_q <= ADT_READ_ZERO;
      rd_valid_q <= 1'b0;
    end else begin
      rd_data_q <= rd_data_d;
      rd_valid_q <= i_req.rd;
    end
  end

  // Five-percent-step recopy codes in output order
  logic [ADT_NUM_STEP5-1:0][2:0] step5_code;
  logic signed [ADT_NUM_STEP5-1:0][7:0] step5_pct;
  logic [ADT_NUM_STEP5-1:0] step5_rsv;
  assign step5_code[0] = trim_q.bridge_pair_b_high_sense_trim;
  assign step5_code[1] = trim_q.bridge_pair_a_high_sense_trim;
  assign step5_code[2] = trim_q.high_side_pair_trim;
  assign step5_code[3] = trim_q.high_side_one_trim;

  // One decoder per three-bit field
  for (genvar g = 0; g < ADT_NUM_STEP5; g++) begin : g_step5
    adt_recopy_decode u_dec (
      .i_code(step5_code[g]),
      .o_pct(step5_pct[g]),
      .o_reserved(step5_rsv[g])
    );
  end

  // Reserved codes in any field are reported; unlisted reference codes too
  wire logic ref_rsv = (ref_trim_q > 4'h8);
  wire logic any_rsv = ref_rsv || (|step5_rsv);

  // Decoded adjustments, registered so the analog side sees clean levels
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ref_pct_q <= 8'sh00;
      recopy_pct_q <= '0;
      reserved_q <= 1'b0;
    end else begin
      ref_pct_q <= adt_ref_pct(ref_trim_q);
      recopy_pct_q[0] <= adt_low_pct(trim_q.bridge_pair_a_low_sense_trim);
      recopy_pct_q[1] <= step5_pct[0];
      recopy_pct_q[2] <= step5_pct[1];
      recopy_pct_q[3] <= adt_low_pct(trim_q.bridge_pair_b_low_sense_trim);
      recopy_pct_q[4] <= step5_pct[2];
      recopy_pct_q[5] <= step5_pct[3];
      reserved_q <= any_rsv;
    end
  end

  // Comparator level is asynchronous; two flops before the filter reads it
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      oc_meta_q <= 1'b0;
      oc_sync_q <= 1'b0;
    end else begin
      oc_meta_q <= i_oc_raw;
      oc_sync_q <= oc_meta_q;
    end
  end

  // Filter delay taken from the stored select
  adt_oc_filter #(
    .CNT_W(CNT_W),
    .CYC0(OC_CYC0),
    .CYC1(OC_CYC1),
    .CYC2(OC_CYC2),
    .CYC3(OC_CYC3)
  ) u_oc_filter (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_level(oc_sync_q),
    .i_sel(dly_sel_q),
    .i_clear(i_oc_clear),
    .o_trip(o_oc_shutdown)
  );

  // Outputs straight from storage
  assign o_rd_data = rd_data_q;
  assign o_rd_valid = rd_valid_q;
  assign o_overcurrent_filter_delay_select = dly_sel_q;
  assign o_current_reference_trim = ref_trim_q;
  assign o_recopy_trim = trim_q;
  assign o_reference_adjust_pct = ref_pct_q;
  assign o_recopy_adjust_pct = recopy_pct_q;
  assign o_reserved_code = reserved_q;
  assign o_trim_loaded = loaded_q;

endmodule : adt_trim_bank

/* hdl/adt_pkg.sv */
// Constants, field layout and carrier types for the analog die trim bank
package adt_pkg;

  // Register offsets on the analog die register port
  localparam logic [7:0] ADT_OFS_PROD_TEST = 8'h0e;
  localparam logic [7:0] ADT_OFS_TRIM_ONE = 8'h0f;
  localparam logic [7:0] ADT_OFS_TRIM_TWO = 8'h10;
  localparam logic [7:0] ADT_OFS_TRIM_THREE = 8'h11;

  // Values after reset
  localparam logic [7:0] ADT_RST_PROD_TEST = 8'h00;
  localparam logic [7:0] ADT_RST_TRIM = 8'h00;
  localparam logic [7:0] ADT_READ_ZERO = 8'h00;

  // Field positions in trim register one
  localparam int ADT_DLY_LSB = 6;
  localparam int ADT_RSV_LSB = 4;
  localparam int ADT_REF_LSB = 0;
  // Field positions in trim registers two and three
  localparam int ADT_LOW_LSB = 6;
  localparam int ADT_HIGH_B_LSB = 3;
  localparam int ADT_HIGH_A_LSB = 0;

  // Clock and filter delay figures
  localparam int ADT_CLK_PERIOD_NS = 25;
  localparam int ADT_OC_DELAY0_NS = 950_000;
  localparam int ADT_OC_DELAY1_NS = 536_000;
  localparam int ADT_OC_DELAY2_NS = 234_000;
  localparam int ADT_OC_DELAY3_NS = 78_000;
  localparam int ADT_OC_CYC0 = (ADT_OC_DELAY0_NS + ADT_CLK_PERIOD_NS - 1) / ADT_CLK_PERIOD_NS;
  localparam int ADT_OC_CYC1 = (ADT_OC_DELAY1_NS + ADT_CLK_PERIOD_NS - 1) / ADT_CLK_PERIOD_NS;
  localparam int ADT_OC_CYC2 = (ADT_OC_DELAY2_NS + ADT_CLK_PERIOD_NS - 1) / ADT_CLK_PERIOD_NS;
  localparam int ADT_OC_CYC3 = (ADT_OC_DELAY3_NS + ADT_CLK_PERIOD_NS - 1) / ADT_CLK_PERIOD_NS;
  localparam int ADT_OC_CNT_W = 16;

  // Number of five-percent-step recopy fields, then of all recopy fields
  localparam int ADT_NUM_STEP5 = 4;
  localparam int ADT_NUM_RECOPY = 6;

  // Register port request from the serial link decoder
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } adt_req_type;

  // Current recopy trim fields as held by the bank
  typedef struct packed {
    logic [1:0] bridge_pair_a_low_sense_trim;
    logic [2:0] bridge_pair_b_high_sense_trim;
    logic [2:0] bridge_pair_a_high_sense_trim;
    logic [1:0] bridge_pair_b_low_sense_trim;
    logic [2:0] high_side_pair_trim;
    logic [2:0] high_side_one_trim;
  } adt_trim_type;

  // Reference trim code to signed percent; undefined codes give no adjustment
  function automatic logic signed [7:0] adt_ref_pct(input logic [3:0] code);
    logic signed [7:0] pct;
    pct = 8'sh00;
    unique case (code)
      4'h1: pct = 8'sd2;
      4'h2: pct = 8'sd4;
      4'h3: pct = 8'sd8;
      4'h4: pct = 8'sd12;
      4'h5: pct = -8'sd2;
      4'h6: pct = -8'sd4;
      4'h7: pct = -8'sd8;
      4'h8: pct = -8'sd12;
      default: pct = 8'sh00;
    endcase
    return pct;
  endfunction : adt_ref_pct

  // Two-bit low-sense recopy code to signed percent
  function automatic logic signed [7:0] adt_low_pct(input logic [1:0] code);
    logic signed [7:0] pct;
    pct = 8'sh00;
    unique case (code)
      2'b00: pct = 8'sh00;
      2'b01: pct = -8'sd10;
      2'b10: pct = 8'sd5;
      2'b11: pct = 8'sd10;
    endcase
    return pct;
  endfunction : adt_low_pct

endpackage : adt_pkg

/* hdl/adt_recopy_decode.sv */
// Decoder for one three-bit five-percent-step recopy trim code
`timescale 1ns/100ps
module adt_recopy_decode (
  input wire logic [2:0] i_code,
  output logic signed [7:0] o_pct,
  output logic o_reserved
);
  import adt_pkg::*;

  // Sign from the top bit, magnitude in five-percent steps from the low bits
  wire logic is_positive = i_code[2];
  wire logic [1:0] steps = i_code[1:0];
  wire logic signed [7:0] magnitude = (steps == 2'b00) ? 8'sh00 :
                                     (steps == 2'b01) ? 8'sd5 :
                                     (steps == 2'b10) ? 8'sd10 : 8'sd15;

  // Code 100 is reserved; it is flagged and applies no adjustment
  assign o_reserved = is_positive && (steps == 2'b00);
  assign o_pct = is_positive ? magnitude : -magnitude;

endmodule : adt_recopy_decode

/* hdl/adt_oc_filter.sv */
// Over-current detection filter with selectable delay for the high-side supply
`timescale 1ns/100ps
module adt_oc_filter #(
  parameter int CNT_W = 16,
  parameter int CYC0 = 38000,
  parameter int CYC1 = 21440,
  parameter int CYC2 = 9360,
  parameter int CYC3 = 3120
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_level,
  input wire logic [1:0] i_sel,
  input wire logic i_clear,
  output logic o_trip
);
  import adt_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic trip_q;
  logic trip_d;

  // Limit follows the live select, so a shorter delay applies at once
  wire logic [CNT_W-1:0] limit = (i_sel == 2'b00) ? CNT_W'(CYC0) :
                                 (i_sel == 2'b01) ? CNT_W'(CYC1) :
                                 (i_sel == 2'b10) ? CNT_W'(CYC2) : CNT_W'(CYC3);
  wire logic reached = i_level && (cnt_q >= limit - CNT_W'(1));

  // Count consecutive cycles of over-current, saturate at the limit
  assign cnt_d = !i_level ? '0 : (cnt_q >= limit) ? cnt_q : cnt_q + CNT_W'(1);
  // Trip is sticky; a new trip in the clearing cycle wins over the clear
  assign trip_d = reached ? 1'b1 : i_clear ? 1'b0 : trip_q;

  // Filter state
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cnt_q <= '0;
      trip_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      trip_q <= trip_d;
    end
  end

  assign o_trip = trip_q;

endmodule : adt_oc_filter

/* test/adt_trim_bank_asserts.sv */
// Port checker for the analog die trim bank
`timescale 1ns/100ps
module adt_trim_bank_chk
  import adt_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire adt_pkg::adt_req_type i_req,
  input wire logic [7:0] o_rd_data,
  input wire logic o_rd_valid,
  input wire logic [1:0] o_overcurrent_filter_delay_select,
  input wire logic [3:0] o_current_reference_trim,
  input wire adt_pkg::adt_trim_type o_recopy_trim,
  input wire logic signed [ADT_NUM_RECOPY-1:0][7:0] o_recopy_adjust_pct,
  input wire logic o_reserved_code,
  input wire logic [2:0] o_trim_loaded,
  input wire logic i_oc_clear,
  input wire logic o_oc_shutdown
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // Request decode; one request per cycle at most
  wire rd_any = i_req.rd;
  wire wr_one = i_req.wr && i_req.addr == ADT_OFS_TRIM_ONE;
  wire wr_two = i_req.wr && i_req.addr == ADT_OFS_TRIM_TWO;
  wire wr_three = i_req.wr && i_req.addr == ADT_OFS_TRIM_THREE;
  wire wr_test = i_req.wr && i_req.addr == ADT_OFS_PROD_TEST;
  rd_valid_on_a: assert property (rd_any |=> o_rd_valid) else $error("read valid missing");
  rd_valid_off_a: assert property (!rd_any |=> !o_rd_valid) else $error("stray read valid");
  rd_zero_regs_a: assert property (rd_any && i_req.addr != ADT_OFS_TRIM_ONE
    |=> o_rd_data == ADT_READ_ZERO) else $error("register read not zero");
  rd_trim_one_a: assert property (rd_any && !i_req.wr && i_req.addr == ADT_OFS_TRIM_ONE
    |=> o_rd_data == {o_overcurrent_filter_delay_select, 6'h00}) else $error("trim one read");
  delay_ref_wr_a: assert property (wr_one |=> ($past(i_req.wdata) & 8'hcf) ==
    {o_overcurrent_filter_delay_select, 2'b00, o_current_reference_trim}) else $error("trim one");
  trim_two_wr_a: assert property (wr_two |=> o_recopy_trim[15:8] == $past(i_req.wdata))
    else $error("trim two write lost");
  trim_three_wr_a: assert property (wr_three |=> o_recopy_trim[7:0] == $past(i_req.wdata))
    else $error("trim three write lost");
  prod_write_ign_a: assert property (wr_test |=> $stable(o_recopy_trim)
    && $stable({o_overcurrent_filter_delay_select, o_current_reference_trim}))
    else $error("test register write took effect");
  reset_clear_a: assert property ($fell(i_rst) |-> o_recopy_trim == '0
    && {o_overcurrent_filter_delay_select, o_current_reference_trim} == 6'h00)
    else $error("fields not cleared by reset");
  reserved_flag_a: assert property (wr_two && i_req.wdata[2:0] == 3'h4
    |=> ##1 o_reserved_code && o_recopy_adjust_pct[2] == 8'sh00) else $error("reserved code");
  // Trip stays latched until a clear arrives
  trip_hold_a: assert property (o_oc_shutdown && !i_oc_clear |=> o_oc_shutdown)
    else $error("shutdown dropped without clear");
  // Main scenarios reached
  cover property (wr_two);
  cover property (rd_any && i_req.addr == ADT_OFS_TRIM_ONE);
  cover property ($fell(i_rst) && o_trim_loaded == 3'h0);
endmodule : adt_trim_bank_chk

bind adt_trim_bank adt_trim_bank_chk adt_trim_bank_chk_i (.i_clk_sys, .i_rst, .i_req,
  .o_rd_data, .o_rd_valid, .o_overcurrent_filter_delay_select, .o_current_reference_trim,
  .o_recopy_trim, .o_recopy_adjust_pct, .o_reserved_code, .o_trim_loaded, .i_oc_clear,
  .o_oc_shutdown);

/* test/adt_mcu_model.sv */
// Controlling die model issuing requests on the trim bank port
`timescale 1ns/100ps
module adt_mcu_model
  import adt_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rd_valid,
  input wire logic [7:0] i_rd_data,
  output adt_pkg::adt_req_type o_req
);
  initial o_req = '0;
  // Called at a falling edge; request is taken at the next rising edge
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data,
                        output logic vld, output logic [7:0] rdat);
    o_req = '{wr: wr, rd: !wr, addr: addr, wdata: data};
    @(negedge i_clk_sys);
    vld = i_rd_valid;
    rdat = i_rd_data;
  endtask : access
  // Release the port for one cycle
  task automatic idle();
    o_req = '0;
    @(negedge i_clk_sys);
  endtask : idle
  // Factory bytes in register order, reserved bits kept clear, test register untouched
  task automatic load(input logic [7:0] t1, t2, t3, input int gap);
    logic v;
    logic [7:0] d;
    access(1'b1, ADT_OFS_TRIM_ONE, t1 & 8'hcf, v, d);
    repeat (gap) idle();
    access(1'b1, ADT_OFS_TRIM_TWO, t2, v, d);
    repeat (gap) idle();
    access(1'b1, ADT_OFS_TRIM_THREE, t3, v, d);
    idle();
  endtask : load
endmodule : adt_mcu_model

/* test/adt_trim_bank_bench.sv */
// Self-checking bench for the analog die trim bank
`timescale 1ns/100ps
module adt_trim_bank_bench;
  import adt_pkg::*;
  localparam int CYC [4] = '{40, 20, 10, 5};
  localparam logic [7:0] P2 [4] = '{8'h00, 8'hf6, 8'h05, 8'h0a};
  localparam logic [7:0] PR [9] = '{8'h00, 8'h02, 8'h04, 8'h08, 8'h0c, 8'hfe, 8'hfc, 8'hf8,
    8'hf4};
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_oc_raw = 1'b0;
  logic i_oc_clear = 1'b0;
  adt_req_type req;
  logic [7:0] rd_data;
  logic rd_valid;
  logic [1:0] dly;
  logic [3:0] rtrim;
  adt_trim_type rc;
  logic signed [7:0] ref_pct;
  logic signed [ADT_NUM_RECOPY-1:0][7:0] rc_pct;
  logic rsv;
  logic [2:0] loaded;
  logic trip;
  int n_mismatch = 0;
  int checked = 0;

  adt_trim_bank #(.OC_CYC0(CYC[0]), .OC_CYC1(CYC[1]), .OC_CYC2(CYC[2]), .OC_CYC3(CYC[3]))
  adt_trim_bank_i (.i_clk_sys, .i_rst, .i_req(req), .i_oc_raw, .i_oc_clear,
    .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_overcurrent_filter_delay_select(dly),
    .o_current_reference_trim(rtrim), .o_recopy_trim(rc), .o_reference_adjust_pct(ref_pct),
    .o_recopy_adjust_pct(rc_pct), .o_reserved_code(rsv), .o_trim_loaded(loaded),
    .o_oc_shutdown(trip));
  adt_mcu_model adt_mcu_model_i (.i_clk_sys, .i_rd_valid(rd_valid), .i_rd_data(rd_data),
    .o_req(req));

  // 40 MHz clock
  initial begin
    forever #12.5 i_clk_sys = !i_clk_sys;
  end

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  // Five-percent-step code; reserved 100 falls out as no adjustment
  function automatic logic [7:0] p3(input logic [2:0] c);
    return c[2] ? 8'(5 * c[1:0]) : 8'(-5 * c[1:0]);
  endfunction : p3

  // Stored fields and decoded outputs after a load settles
  task automatic expect_trims(input logic [7:0] t1, t2, t3);
    check("delay", dly, t1[7:6]);
    check("ref", rtrim, t1[3:0]);
    check("recopy", rc, {t2, t3});
    check("ref_pct", {ref_pct}, t1[3:0] > 8 ? 8'h00 : PR[t1[3:0]]);
    check("a_lo", {rc_pct[0]}, P2[t2[7:6]]);
    check("b_hi", {rc_pct[1]}, p3(t2[5:3]));
    check("a_hi", {rc_pct[2]}, p3(t2[2:0]));
    check("b_lo", {rc_pct[3]}, P2[t3[7:6]]);
    check("hs_pair", {rc_pct[4]}, p3(t3[5:3]));
    check("hs_one", {rc_pct[5]}, p3(t3[2:0]));
    check("rsv", rsv, t1[3:0] > 8 || t2[5:3] == 4 || t2[2:0] == 4 ||
      t3[5:3] == 4 || t3[2:0] == 4);
  endtask : expect_trims

  // Hang guard
  initial begin
    #2_500_000;
    n_mismatch++;
    test_done();
  end

  // Main sequence
  initial begin
    logic [7:0] b [3];
    logic v;
    logic [7:0] d;
    int cnt;
    void'($urandom(13637));
    repeat (8) @(negedge i_clk_sys);
    i_rst = 1'b0;
    check("cleared", {dly, rtrim, loaded}, 16'h0000);
    check("cleared_rc", rc, 16'h0000);
    // Every register and two unmapped places read back zero
    for (int a = 13; a < 19; a++) begin
      adt_mcu_model_i.access(1'b0, 8'(a), 8'h00, v, d);
      check("rd", {v, d}, 16'h0100);
    end
    // Random factory bytes, then every code but reference codes 9 to 15, back to back or spaced
    foreach (b[k]) b[k] = 8'($urandom);
    adt_mcu_model_i.load(b[0], b[1], b[2], 0);
    repeat (2) @(negedge i_clk_sys);
    expect_trims(b[0] & 8'hcf, b[1], b[2]);
    check("loaded", loaded, 3'h7);
    for (int c = 0; c < 9; c++) begin
      adt_mcu_model_i.load({c[1:0], 2'b11, c[3:0]}, {c[1:0], c[2:0], ~c[2:0]},
        {~c[1:0], c[2:0] + 3'h1, c[2:0]}, c % 2);
      repeat (2) @(negedge i_clk_sys);
      expect_trims({c[1:0], 2'b00, c[3:0]}, {c[1:0], c[2:0], ~c[2:0]},
        {~c[1:0], c[2:0] + 3'h1, c[2:0]});
      adt_mcu_model_i.access(1'b0, ADT_OFS_TRIM_ONE, 8'h00, v, d);
      adt_mcu_model_i.access(1'b0, ADT_OFS_TRIM_TWO, 8'h00, v, b[0]);
      adt_mcu_model_i.idle();
      check("rd_trims", {d, b[0]}, {c[1:0], 14'h0000});
    end
    // Writes to the test register and an unmapped place change nothing
    adt_mcu_model_i.access(1'b1, ADT_OFS_PROD_TEST, 8'($urandom), v, d);
    adt_mcu_model_i.access(1'b1, 8'h12, 8'($urandom), v, d);
    adt_mcu_model_i.access(1'b0, ADT_OFS_PROD_TEST, 8'h00, v, d);
    adt_mcu_model_i.idle();
    check("test_rd", d, 8'h00);
    expect_trims(8'h08, 8'h07, 8'hc8);
    // Filter delay per select, with a short pulse that must not trip
    for (int s = 3; s >= 0; s--) begin
      adt_mcu_model_i.access(1'b1, ADT_OFS_TRIM_ONE, {s[1:0], 6'h00}, v, d);
      adt_mcu_model_i.idle();
      i_oc_raw = 1'b1;
      repeat (CYC[3] - 2) @(negedge i_clk_sys);
      i_oc_raw = 1'b0;
      repeat (10) @(negedge i_clk_sys);
      check("oc_glitch", trip, 1'b0);
      i_oc_raw = 1'b1;
      for (cnt = 1; cnt < 200 && !trip; cnt++) @(negedge i_clk_sys);
      check("oc_delay", 16'(cnt), 16'(CYC[s] + 3));
      if (cnt == 200) test_done();
      i_oc_raw = 1'b0;
      repeat (4) @(negedge i_clk_sys);
      i_oc_clear = 1'b1;
      @(negedge i_clk_sys);
      i_oc_clear = 1'b0;
      @(negedge i_clk_sys);
      check("oc_clear", trip, 1'b0);
    end
    // Reset in mid-run drops every trim until reloaded
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    i_rst = 1'b0;
    check("rst_again", {dly, rtrim, loaded, trip}, 16'h0000);
    check("rst_again_rc", rc, 16'h0000);
    adt_mcu_model_i.load(8'hcc, 8'h6d, 8'h3e, 1);
    repeat (2) @(negedge i_clk_sys);
    expect_trims(8'hcc, 8'h6d, 8'h3e);
    test_done();
  end
endmodule : adt_trim_bank_bench
